// File: bench/can_rx_protect_timestamp_test.sv
// self-checking bench of the receive-protect and time-stamp block
`timescale 1ns/1ns
`include "crp_cfg.svh"
module can_rx_protect_timestamp_test;
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = '0, pend = '0, dir = '0, rx_mask = '0, tx_mask = '0;
  logic        prot = 1'b0, compat = 1'b0, busy = 1'b0, tick_en = 1'b0, rx_go = 1'b0, tx_go = 1'b0;
  logic [2:0]  halt = 3'b000;
  logic        pready, pslverr, tick, rx_valid, st_o, txf, rxf, ovf, int0, int1, e, st;
  logic [31:0] prdata, rx_match, tx_done, lost_o, stamp_counter, r, base, lost;
  logic [4:0]  idx_o, ix;
  int          errors = 0, checked = 0, nticks = 0;

  always #20 clk = ~clk;
  always @(posedge clk) if (tick === 1'b1) nticks <= nticks + 1;

  crp_node NODE (.clk_i(clk), .nrst_i(nrst), .tick_en_i(tick_en), .rx_go_i(rx_go), .rx_mask_i(rx_mask),
    .tx_go_i(tx_go), .tx_mask_i(tx_mask), .tick_o(tick), .rx_valid_o(rx_valid), .rx_match_o(rx_match),
    .tx_done_o(tx_done));
  crp_top DUT (.CORE_CLK_I(clk), .NRST_I(nrst), .CE_I(1'b1), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .PROT_WR_EN_I(prot), .STD_COMPAT_MODE_I(compat), .INIT_MODE_I(halt[0]),
    .SLEEP_MODE_I(halt[1]), .SUSPEND_MODE_I(halt[2]), .BIT_TICK_I(tick), .PROTO_BUSY_I(busy),
    .RX_VALID_I(rx_valid), .RX_MATCH_I(rx_match), .MSG_PENDING_I(pend), .MBOX_DIR_I(dir),
    .TX_DONE_I(tx_done), .RX_STORE_O(st_o), .RX_STORE_IDX_O(idx_o), .MSG_LOST_SET_O(lost_o),
    .TX_PIN_FUNC_O(txf), .RX_PIN_FUNC_O(rxf), .STAMP_COUNTER_O(stamp_counter), .COUNTER_OVF_FLAG_O(ovf),
    .INT_LINE0_O(int0), .INT_LINE1_O(int1));

  task automatic tally_and_finish();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // whole-word transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // ready, data and error are taken at the rising edge that sees ready high
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string m);
    apb(1'b0, a, '0);
    chk(r, x, m);
  endtask

  task automatic run_ticks(input int k);
    tick_en <= 1'b1;
    repeat (k) @(posedge clk);
    tick_en <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic rx(input logic [31:0] m);
    rx_mask <= m;
    rx_go <= 1'b1;
    @(posedge clk);
    rx_go <= 1'b0;
    st = 1'b0;
    ix = '0;
    lost = '0;
    repeat (6) begin
      @(negedge clk);
      if (st_o === 1'b1) begin
        st = 1'b1;
        ix = idx_o;
      end
      lost |= lost_o;
    end
    @(posedge clk);
  endtask

  task automatic t_regs();
    logic [7:0] a;
    rd(`CRP_OFS_OPC, '0, "protect reset");
    rd(`CRP_OFS_TSC, '0, "counter reset");
    apb(1'b0, 8'h40, '0);
    chk(32'(e), 32'h0000_0001, "unmapped error");
    for (int i = 0; i < 2; i++) begin
      a = i ? `CRP_OFS_RIOC : `CRP_OFS_TIOC;
      prot <= 1'b0;
      wr(a, 32'hFFFF_FFFF);
      rd(a, '0, "pin write unprotected");
      prot <= 1'b1;
      wr(a, 32'hFFFF_FFFF);
      rd(a, 32'h0000_0008, "pin bit");
      chk(32'(i ? rxf : txf), 32'h0000_0001, "pin out");
    end
  endtask

  task automatic t_search();
    wr(`CRP_OFS_OPC, 32'hFFFF_FFFF);
    rd(`CRP_OFS_OPC, 32'hFFFF_FFFF, "protect ones");
    wr(`CRP_OFS_OPC, 32'h0000_0020);
    pend <= 32'h0000_0020;
    rx(32'h0000_0028);
    chk(32'({st, ix}), 32'h0000_0023, "kept, next match");
    chk(lost, '0, "no lost when kept");
    rx(32'h0000_0020);
    chk(32'(st), '0, "dropped");
    chk(lost, '0, "dropped silently");
    wr(`CRP_OFS_OPC, '0);
    rx(32'h0000_0020);
    chk(32'({st, ix}), 32'h0000_0025, "overwrite");
    chk(lost, 32'h0000_0020, "lost bit");
    pend <= '0;
  endtask

  task automatic t_counter();
    int n0;
    prot <= 1'b0;
    wr(`CRP_OFS_TSC, 32'h1234_5678);
    rd(`CRP_OFS_TSC, '0, "counter unprotected");
    prot <= 1'b1;
    wr(`CRP_OFS_TSC, 32'h7FFF_FFF0);
    n0 = nticks;
    run_ticks(100);
    base = 32'h7FFF_FFF0 + 32'(nticks - n0);
    rd(`CRP_OFS_TSC, base, "counter advance");
    chk(32'(ovf), 32'h0000_0001, "overflow flag");
    wr(`CRP_OFS_MC, 32'h0000_4000);
    base = base & 32'h7FFF_FFFF;
    chk(stamp_counter, base, "msb clear");
    for (int m = 0; m < 3; m++) begin
      halt <= 3'b001 << m;
      run_ticks(20);
      chk(stamp_counter, base, "counter halted");
    end
    halt <= '0;
    wr(`CRP_OFS_TSC, 32'hFFFF_FFFF);
    n0 = nticks;
    run_ticks(20);
    chk(stamp_counter, 32'(nticks - n0 - 1), "wrap");
    compat <= 1'b1;
    rd(`CRP_OFS_TSC, '0, "compat hides counter");
    compat <= 1'b0;
  endtask

  task automatic t_stamp();
    int n0;
    wr(8'h8C, 32'h5A5A_A5A5);
    rd(8'h8C, 32'h5A5A_A5A5, "stamp read write");
    wr(`CRP_OFS_TSC, 32'h0000_0100);
    busy <= 1'b1;
    rx(32'h0000_0008);
    n0 = nticks;
    run_ticks(40);
    busy <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h8C, 32'h0000_0100 + 32'(nticks - n0), "stamp after busy");
    wr(`CRP_OFS_MC, 32'h0000_8000);
    wr(`CRP_OFS_TSC, 32'h0000_0300);
    tx_mask <= 32'h0001_0000;
    tx_go <= 1'b1;
    @(posedge clk);
    tx_go <= 1'b0;
    repeat (6) @(posedge clk);
    chk(stamp_counter, '0, "tx 16 clears");
    rd(8'hC0, '0, "tx stamp");
    wr(`CRP_OFS_TSC, 32'h0000_0300);
    dir <= 32'h0001_0000;
    rx(32'h0001_0000);
    chk(stamp_counter, '0, "rx 16 clears");
  endtask

  task automatic t_irq();
    wr(`CRP_OFS_GIM, '0);
    repeat (2) @(posedge clk);
    chk(32'({int1, int0}), '0, "masked");
    wr(`CRP_OFS_GIM, 32'h0001_0000);
    repeat (2) @(posedge clk);
    chk(32'({int1, int0}), 32'h0000_0001, "line 0");
    wr(`CRP_OFS_GIM, 32'h0001_0004);
    repeat (2) @(posedge clk);
    chk(32'({int1, int0}), 32'h0000_0002, "line 1");
    wr(`CRP_OFS_GIF, 32'h0001_0000);
    repeat (2) @(posedge clk);
    chk(32'(ovf), '0, "overflow flag cleared");
    chk(32'({int1, int0}), '0, "lines quiet after clear");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_search();
    t_counter();
    t_stamp();
    t_irq();
    tally_and_finish();
  end
endmodule // can_rx_protect_timestamp_test

// File: bench/crp_node.sv
// bus-side node model: bit clock ticks and frame completions
`timescale 1ns/1ns
module crp_node #(
  parameter int BIT_CYC = 4
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        tick_en_i,
  input  wire logic        rx_go_i,
  input  wire logic [31:0] rx_mask_i,
  input  wire logic        tx_go_i,
  input  wire logic [31:0] tx_mask_i,
  output logic             tick_o,
  output logic             rx_valid_o,
  output logic [31:0]      rx_match_o,
  output logic [31:0]      tx_done_o
);
  int div;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div <= 0;
      tick_o <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_match_o <= '0;
      tx_done_o <= '0;
    end else begin
      div <= (div == BIT_CYC - 1) ? 0 : div + 1;
      // one pulse per bit time, none while tick_en_i is low
      tick_o <= tick_en_i && (div == 0);
      rx_valid_o <= rx_go_i;
      // match lines hold junk outside the completion pulse
      rx_match_o <= rx_go_i ? rx_mask_i : ~rx_mask_i;
      tx_done_o <= tx_go_i ? tx_mask_i : '0;
    end
  end
endmodule // crp_node

// File: core/crp_cfg.svh
// constants of the receive-protect and time-stamp block
`ifndef CRP_CFG_SVH
`define CRP_CFG_SVH
`define CRP_NMBOX        32
`define CRP_IDX_W        5
`define CRP_AW           8
`define CRP_DW           32
`define CRP_MSB          31
`define CRP_ZERO32       32'h0000_0000
`define CRP_ONE32        32'h0000_0001
`define CRP_ONES32       32'hFFFF_FFFF
`define CRP_OFS_OPC      8'h00
`define CRP_OFS_TIOC     8'h04
`define CRP_OFS_RIOC     8'h08
`define CRP_OFS_TSC      8'h0C
`define CRP_OFS_MC       8'h10
`define CRP_OFS_GIF      8'h14
`define CRP_OFS_GIM      8'h18
`define CRP_MAILBOX_STAMP_VALUE_BIT     7
`define CRP_MAILBOX_STAMP_VALUE_IDX_HI  6
`define CRP_MAILBOX_STAMP_VALUE_IDX_LO  2
`define CRP_ALIGN_HI     1
`define CRP_ALIGN_LO     0
`define CRP_PIN_FUNC_BIT 3
`define CRP_MC_TCC_BIT   14
`define CRP_MC_MAILBOX16_COUNTER_CLEAR_ENABLE_BIT  15
`define CRP_GIF_OVF_BIT  16
`define CRP_GIM_MASK_BIT 16
`define CRP_GIM_GIL_BIT  2
`define CRP_SYNC_MBOX    16
`endif

// File: core/crp_mbox_search.sv
// receive mailbox search with overwrite protection
`timescale 1ns/1ns
`include "crp_cfg.svh"
module crp_mbox_search (
  input  wire logic [`CRP_NMBOX-1:0] match_i,
  input  wire logic [`CRP_NMBOX-1:0] pending_i,
  input  wire logic [`CRP_NMBOX-1:0] protect_i,
  output logic                       found_o,
  output logic [`CRP_IDX_W-1:0]      idx_o,
  output logic                       overwrite_o
);
  logic [`CRP_NMBOX-1:0] cand;

  always_comb begin
    // full and protected mailboxes drop out, search goes on
    cand        = match_i & ~(pending_i & protect_i);
    found_o     = |cand;
    idx_o       = crp_pkg::top_set(cand);
    overwrite_o = found_o & pending_i[idx_o];
  end
endmodule // crp_mbox_search

// File: core/crp_pkg.sv
// types and decode functions of the receive-protect and time-stamp block
`include "crp_cfg.svh"
package crp_pkg;
  typedef enum logic [0:0] {
    TC_IDLE  = 1'b0,
    TC_WRITE = 1'b1
  } crp_tc_state_type;

  typedef enum logic [3:0] {
    R_OPC  = 4'h0,
    R_TIOC = 4'h1,
    R_RIOC = 4'h2,
    R_TSC  = 4'h3,
    R_MC   = 4'h4,
    R_GIF  = 4'h5,
    R_GIM  = 4'h6,
    R_MAILBOX_STAMP_VALUE = 4'h7,
    R_NONE = 4'h8
  } crp_reg_type;

  typedef struct packed {
    logic [`CRP_DW-1:0]                    overwrite_protect_bit;
    logic                                  tx_func;
    logic                                  rx_func;
    logic [`CRP_DW-1:0]                    stamp_counter;
    logic                                  mailbox16_counter_clear_enable;
    logic                                  ovf_flag;
    logic                                  ovf_mask;
    logic                                  global_interrupt_level;
    logic [`CRP_NMBOX-1:0][`CRP_DW-1:0]    mailbox_stamp_value;
    logic [`CRP_NMBOX-1:0]                 stamp_pend;
    crp_tc_state_type                      tc_state;
    logic [`CRP_IDX_W-1:0]                 tc_idx;
    logic                                  pready;
    logic                                  pslverr;
    logic [`CRP_DW-1:0]                    prdata;
    logic                                  rx_store;
    logic [`CRP_IDX_W-1:0]                 rx_idx;
    logic [`CRP_NMBOX-1:0]                 lost_set;
    logic                                  int0;
    logic                                  int1;
  } crp_state_type;

  // highest mailbox number whose bit is set
  function automatic logic [`CRP_IDX_W-1:0] top_set(input logic [`CRP_NMBOX-1:0] v);
    logic [`CRP_IDX_W-1:0] r;
    r = '0;
    for (int i = 0; i < `CRP_NMBOX; i++) begin
      if (v[i]) begin
        r = i[`CRP_IDX_W-1:0];
      end
    end
    return r;
  endfunction

  function automatic crp_reg_type reg_sel(input logic [`CRP_AW-1:0] a);
    crp_reg_type r;
    r = R_NONE;
    if (a[`CRP_ALIGN_HI:`CRP_ALIGN_LO] == 2'b00) begin
      if (a[`CRP_MAILBOX_STAMP_VALUE_BIT]) begin
        r = R_MAILBOX_STAMP_VALUE;
      end else begin
        unique case (a)
          `CRP_OFS_OPC:  r = R_OPC;
          `CRP_OFS_TIOC: r = R_TIOC;
          `CRP_OFS_RIOC: r = R_RIOC;
          `CRP_OFS_TSC:  r = R_TSC;
          `CRP_OFS_MC:   r = R_MC;
          `CRP_OFS_GIF:  r = R_GIF;
          `CRP_OFS_GIM:  r = R_GIM;
          default:       r = R_NONE;
        endcase
      end
    end
    return r;
  endfunction
endpackage

// File: core/crp_top.sv
// receive overwrite protection, pin function and time-stamp unit with APB slave
`timescale 1ns/1ns
`include "crp_cfg.svh"
module crp_top (
  input  wire logic                  CORE_CLK_I,
  input  wire logic                  NRST_I,
  input  wire logic                  CE_I,
  input  wire logic                  PSEL_I,
  input  wire logic                  PENABLE_I,
  input  wire logic                  PWRITE_I,
  input  wire logic [`CRP_AW-1:0]    PADDR_I,
  input  wire logic [`CRP_DW-1:0]    PWDATA_I,
  output logic      [`CRP_DW-1:0]    PRDATA_O,
  output logic                       PREADY_O,
  output logic                       PSLVERR_O,
  input  wire logic                  PROT_WR_EN_I,
  input  wire logic                  STD_COMPAT_MODE_I,
  input  wire logic                  INIT_MODE_I,
  input  wire logic                  SLEEP_MODE_I,
  input  wire logic                  SUSPEND_MODE_I,
  input  wire logic                  BIT_TICK_I,
  input  wire logic                  PROTO_BUSY_I,
  input  wire logic                  RX_VALID_I,
  input  wire logic [`CRP_NMBOX-1:0] RX_MATCH_I,
  input  wire logic [`CRP_NMBOX-1:0] MSG_PENDING_I,
  input  wire logic [`CRP_NMBOX-1:0] MBOX_DIR_I,
  input  wire logic [`CRP_NMBOX-1:0] TX_DONE_I,
  output logic                       RX_STORE_O,
  output logic      [`CRP_IDX_W-1:0] RX_STORE_IDX_O,
  output logic      [`CRP_NMBOX-1:0] MSG_LOST_SET_O,
  output logic                       TX_PIN_FUNC_O,
  output logic                       RX_PIN_FUNC_O,
  output logic      [`CRP_DW-1:0]    STAMP_COUNTER_O,
  output logic                       COUNTER_OVF_FLAG_O,
  output logic                       INT_LINE0_O,
  output logic                       INT_LINE1_O
);
  crp_pkg::crp_state_type st;
  crp_pkg::crp_state_type next_st;
  crp_pkg::crp_reg_type   sel;

  logic                  found;
  logic [`CRP_IDX_W-1:0] s_idx;
  logic                  overwrite;
  logic                  acc_phase;
  logic                  wr;
  logic                  tsc_wr;
  logic                  tcc_wr;
  logic                  mb16_clr;
  logic                  stopped;
  logic                  rx_hit;
  logic [`CRP_NMBOX-1:0] rx_onehot;
  logic [`CRP_NMBOX-1:0] stamp_ev;
  logic [`CRP_NMBOX-1:0] stamp_clr;
  logic [`CRP_DW-1:0]    rd;
  logic [`CRP_IDX_W-1:0] m_idx;

  crp_mbox_search u_search (
    .match_i     (RX_MATCH_I),
    .pending_i   (MSG_PENDING_I),
    .protect_i   (st.overwrite_protect_bit),
    .found_o     (found),
    .idx_o       (s_idx),
    .overwrite_o (overwrite)
  );

  always_comb begin
    next_st   = st;
    sel       = crp_pkg::reg_sel(PADDR_I);
    m_idx     = PADDR_I[`CRP_MAILBOX_STAMP_VALUE_IDX_HI:`CRP_MAILBOX_STAMP_VALUE_IDX_LO];
    acc_phase = PSEL_I & PENABLE_I;
    // whole-word writes only, taken at the edge with pready high
    wr        = acc_phase & st.pready & PWRITE_I & ~st.pslverr;
    stopped   = INIT_MODE_I | SLEEP_MODE_I | SUSPEND_MODE_I;
    rx_hit    = RX_VALID_I & found;
    rx_onehot = `CRP_ONE32 << s_idx;

    // read mux
    rd = `CRP_ZERO32;
    unique case (sel)
      crp_pkg::R_OPC:  rd = st.overwrite_protect_bit;
      crp_pkg::R_TIOC: rd[`CRP_PIN_FUNC_BIT] = st.tx_func;
      crp_pkg::R_RIOC: rd[`CRP_PIN_FUNC_BIT] = st.rx_func;
      crp_pkg::R_TSC:  rd = STD_COMPAT_MODE_I ? `CRP_ZERO32 : st.stamp_counter;
      crp_pkg::R_MC:   rd[`CRP_MC_MAILBOX16_COUNTER_CLEAR_ENABLE_BIT] = st.mailbox16_counter_clear_enable;
      crp_pkg::R_GIF:  rd[`CRP_GIF_OVF_BIT] = st.ovf_flag;
      crp_pkg::R_GIM: begin
        rd[`CRP_GIM_MASK_BIT] = st.ovf_mask;
        rd[`CRP_GIM_GIL_BIT]  = st.global_interrupt_level;
      end
      crp_pkg::R_MAILBOX_STAMP_VALUE: rd = st.mailbox_stamp_value[m_idx];
      crp_pkg::R_NONE: rd = `CRP_ZERO32;
    endcase

    // one wait state, then answer
    next_st.pready  = acc_phase & ~st.pready;
    next_st.pslverr = acc_phase & ~st.pready & (sel == crp_pkg::R_NONE);
    if (acc_phase & ~st.pready) begin
      next_st.prdata = PWRITE_I ? `CRP_ZERO32 : rd;
    end

    // software registers
    if (wr && sel == crp_pkg::R_OPC) begin
      next_st.overwrite_protect_bit = PWDATA_I;
    end
    if (wr && sel == crp_pkg::R_TIOC && PROT_WR_EN_I) begin
      next_st.tx_func = PWDATA_I[`CRP_PIN_FUNC_BIT];
    end
    if (wr && sel == crp_pkg::R_RIOC && PROT_WR_EN_I) begin
      next_st.rx_func = PWDATA_I[`CRP_PIN_FUNC_BIT];
    end
    tcc_wr = wr && sel == crp_pkg::R_MC && PWDATA_I[`CRP_MC_TCC_BIT];
    if (wr && sel == crp_pkg::R_MC) begin
      next_st.mailbox16_counter_clear_enable = PWDATA_I[`CRP_MC_MAILBOX16_COUNTER_CLEAR_ENABLE_BIT];
    end
    if (wr && sel == crp_pkg::R_GIM) begin
      next_st.ovf_mask = PWDATA_I[`CRP_GIM_MASK_BIT];
      next_st.global_interrupt_level      = PWDATA_I[`CRP_GIM_GIL_BIT];
    end
    if (wr && sel == crp_pkg::R_GIF && PWDATA_I[`CRP_GIF_OVF_BIT]) begin
      next_st.ovf_flag = 1'b0;
    end
    if (wr && sel == crp_pkg::R_MAILBOX_STAMP_VALUE) begin
      next_st.mailbox_stamp_value[m_idx] = PWDATA_I;
    end

    // time-stamp counter
    tsc_wr   = wr && sel == crp_pkg::R_TSC && PROT_WR_EN_I && !STD_COMPAT_MODE_I;
    mb16_clr = st.mailbox16_counter_clear_enable & (MBOX_DIR_I[`CRP_SYNC_MBOX] ?
               (rx_hit && s_idx == `CRP_IDX_W'(`CRP_SYNC_MBOX)) :
               TX_DONE_I[`CRP_SYNC_MBOX]);
    if (tsc_wr) begin
      next_st.stamp_counter = PWDATA_I;
    end else if (mb16_clr) begin
      next_st.stamp_counter = `CRP_ZERO32;
    end else begin
      if (BIT_TICK_I && !stopped) begin
        // all ones rolls over to zero
        next_st.stamp_counter = st.stamp_counter + `CRP_ONE32;
      end
      if (tcc_wr) begin
        next_st.stamp_counter[`CRP_MSB] = 1'b0;
      end
    end
    // set beats a same-cycle clear
    if (!st.stamp_counter[`CRP_MSB] && next_st.stamp_counter[`CRP_MSB]) begin
      next_st.ovf_flag = 1'b1;
    end

    // receive outcome towards the mailbox logic
    next_st.rx_store = rx_hit;
    next_st.rx_idx   = s_idx;
    next_st.lost_set = (rx_hit && overwrite) ? rx_onehot : `CRP_ZERO32;

    // stamp capture, deferred behind protocol accesses
    stamp_ev  = (rx_hit ? rx_onehot : `CRP_ZERO32) | TX_DONE_I;
    stamp_clr = `CRP_ZERO32;
    unique case (st.tc_state)
      crp_pkg::TC_IDLE: begin
        if (|st.stamp_pend) begin
          next_st.tc_state = crp_pkg::TC_WRITE;
          next_st.tc_idx   = crp_pkg::top_set(st.stamp_pend);
        end
      end
      crp_pkg::TC_WRITE: begin
        if (!PROTO_BUSY_I) begin
          next_st.mailbox_stamp_value[st.tc_idx] = st.stamp_counter;
          stamp_clr = `CRP_ONE32 << st.tc_idx;
          next_st.tc_state = crp_pkg::TC_IDLE;
        end
      end
    endcase
    next_st.stamp_pend = (st.stamp_pend & ~stamp_clr) | stamp_ev;

    // interrupt routing
    next_st.int0 = st.ovf_flag & st.ovf_mask & ~st.global_interrupt_level;
    next_st.int1 = st.ovf_flag & st.ovf_mask & st.global_interrupt_level;
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st <= '0;
    end else if (CE_I) begin
      st <= next_st;
    end
  end

  assign PRDATA_O           = st.prdata;
  assign PREADY_O           = st.pready;
  assign PSLVERR_O          = st.pslverr;
  assign RX_STORE_O         = st.rx_store;
  assign RX_STORE_IDX_O     = st.rx_idx;
  assign MSG_LOST_SET_O     = st.lost_set;
  assign TX_PIN_FUNC_O      = st.tx_func;
  assign RX_PIN_FUNC_O      = st.rx_func;
  assign STAMP_COUNTER_O    = st.stamp_counter;
  assign COUNTER_OVF_FLAG_O = st.ovf_flag;
  assign INT_LINE0_O        = st.int0;
  assign INT_LINE1_O        = st.int1;

  // checks
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!NRST_I || !CE_I);

  a_rx_store_found: assert property (rx_hit |=> RX_STORE_O && RX_STORE_IDX_O == $past(s_idx))
    else $error("matching free mailbox not stored");
  a_rx_silent_drop: assert property (RX_VALID_I && !found |=> !RX_STORE_O && MSG_LOST_SET_O == `CRP_ZERO32)
    else $error("dropped message raised an indication");
  a_rx_overwrite_lost: assert property (rx_hit && overwrite |=> MSG_LOST_SET_O == (`CRP_ONE32 << RX_STORE_IDX_O))
    else $error("overwrite without lost bit");
  a_pin_protect: assert property (wr && sel == crp_pkg::R_TIOC && !PROT_WR_EN_I |=> $stable(TX_PIN_FUNC_O))
    else $error("pin function changed without protected write");
  a_stamp_defer: assert property (st.tc_state == crp_pkg::TC_WRITE && PROTO_BUSY_I && !wr |=> $stable(st.mailbox_stamp_value))
    else $error("stamp written during protocol activity");
  a_stamp_copy: assert property (st.tc_state == crp_pkg::TC_WRITE && !PROTO_BUSY_I
    |=> st.mailbox_stamp_value[$past(st.tc_idx)] == $past(st.stamp_counter))
    else $error("stamp value not captured");
  a_tsc_count: assert property (BIT_TICK_I && !stopped && !tsc_wr && !mb16_clr && !tcc_wr
    |=> STAMP_COUNTER_O == $past(STAMP_COUNTER_O) + `CRP_ONE32)
    else $error("counter did not advance on tick");
  a_tsc_hold: assert property (stopped && !tsc_wr && !mb16_clr && !tcc_wr |=> $stable(STAMP_COUNTER_O))
    else $error("counter moved while stopped");
  a_tcc_msb: assert property (tcc_wr && !tsc_wr && !mb16_clr |=> !STAMP_COUNTER_O[`CRP_MSB])
    else $error("msb not cleared");
  a_mb16_clear: assert property (mb16_clr && !tsc_wr |=> STAMP_COUNTER_O == `CRP_ZERO32)
    else $error("mailbox 16 did not clear counter");
  a_ovf_flag: assert property ($rose(STAMP_COUNTER_O[`CRP_MSB]) |-> COUNTER_OVF_FLAG_O)
    else $error("overflow flag missed");
  a_int_route: assert property (COUNTER_OVF_FLAG_O && st.ovf_mask && st.global_interrupt_level ##1 COUNTER_OVF_FLAG_O
    |-> INT_LINE1_O && !INT_LINE0_O)
    else $error("interrupt on wrong line");
  a_int_line0: assert property (COUNTER_OVF_FLAG_O && st.ovf_mask && !st.global_interrupt_level |=> INT_LINE0_O && !INT_LINE1_O)
    else $error("interrupt not on line 0");
  a_int_masked: assert property (!st.ovf_mask |=> !INT_LINE0_O && !INT_LINE1_O)
    else $error("masked overflow raised an interrupt");

  c_rx_overwrite: cover property (rx_hit && overwrite);
  c_rx_protected: cover property (RX_VALID_I && |(RX_MATCH_I & MSG_PENDING_I & st.overwrite_protect_bit) && found);
  c_overflow: cover property ($rose(COUNTER_OVF_FLAG_O));
  c_stamp_wait: cover property (st.tc_state == crp_pkg::TC_WRITE && PROTO_BUSY_I);
endmodule // crp_top
